/* design/cdmcb_regs.vh */
// Purpose: constants of the dsp misc control bank
// Assumes: 9-bit registers, 7-bit register index
// Notes:   none
//
// How it works
// (R1) target_table_select picks the -1.5 to -22.5 dB table at 0 and the -6.0 to -28.5 dB table at 1.
// (R2) the level threshold uses the rectified peak value at 0 and the peak-to-peak value at 1.
// (R3) the noise gate threshold uses the rectified peak value at 0 and the peak-to-peak value at 1.
// (R4) reading the gain readback fields returns the gain the left and right amplifiers apply right now.
// (R5) the fast peak limiter runs while its control bit is 0, the reset state, and stops at 1.
// (R6) force_four_wire_serial at 1 puts the control port in 4-wire mode whatever the mode pin says.
// (R7) a short frame is a frame under 255 (codes 00, 11), 253 (01) or 254 (10) master clock edges.
// (R8) with short_frame_flush at 1 a short frame resets the processing state, at 0 it is ignored.
// (R9) short frame detection runs while its bit is 0 and is off at 1.
// (R10) a newly enabled notch filter output is used after 512 samples at 0, at once at 1.
// (R11) in soft mute the limiter output is forced to exact zero when exact_zero_mute is 1.
// (R12) an unlocked pll output is blocked at 0 and passed unchanged at 1.
// (R13) the dac oversamples 256x when the override is 1, else follows dac control bit 3.
// (R14) manual_tieoff_enable at 1 lets the manual switch bits override automatic tie-off switching.
// (R15) all registers of the bank reset to 0x000.
// (R16) with manual tie-off on, a manual bit at 0 opens its switch and at 1 closes it.
// (R17) writes to gain readback fields do nothing and reserved bits read zero.
`ifndef CDMCB_REGS_VH
`define CDMCB_REGS_VH
`define CDMCB_ADDR_ENH1        7'h46
`define CDMCB_ADDR_ENH2        7'h47
`define CDMCB_ADDR_MISC        7'h49
`define CDMCB_ADDR_TIEOFF      7'h4a
`define CDMCB_RESET_VAL        9'h000
`define CDMCB_BIT_TABLE        8
`define CDMCB_BIT_LVL_SRC      7
`define CDMCB_BIT_GATE_SRC     6
`define CDMCB_BIT_LIM_DIS      8
`define CDMCB_BIT_FORCE4W      8
`define CDMCB_THR_HI           7
`define CDMCB_THR_LO           6
`define CDMCB_BIT_FLUSH        5
`define CDMCB_BIT_DET_OFF      4
`define CDMCB_BIT_NOTCH_DLY    3
`define CDMCB_BIT_ZERO_MUTE    2
`define CDMCB_BIT_PLL_PASS     1
`define CDMCB_BIT_OSR_OVR      0
`define CDMCB_BIT_MAN_EN       8
`define CDMCB_THR_255          9'd255
`define CDMCB_THR_253          9'd253
`define CDMCB_THR_254          9'd254
`define CDMCB_NOTCH_SAMPLES    10'd512
`endif

/* design/cdmcb_bank.v */
// Purpose: level control enhancement and misc control registers with their effects
// Assumes: register port driven by the serial control interface on the master clock
// Notes:   read data lands one cycle after the read strobe
`include "cdmcb_regs.vh"
`default_nettype none
module cdmcb_bank #(
  parameter GAIN_W = 6,
  parameter PEAK_W = 16,
  parameter AUD_W  = 24
) (
  input  wire              clock,
  input  wire              rst,
  input  wire [6:0]        reg_addr,
  input  wire [8:0]        reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [8:0]        reg_rdata,
  input  wire [GAIN_W-1:0] left_gain,
  input  wire [GAIN_W-1:0] right_gain,
  input  wire [PEAK_W-1:0] peak_rect,
  input  wire [PEAK_W-1:0] peak_p2p,
  output reg  [PEAK_W-1:0] level_detect_value,
  output reg  [PEAK_W-1:0] gate_detect_value,
  output reg               target_table_select,
  output reg               fast_limiter_active,
  input  wire              mode_pin,
  output reg               four_wire_mode,
  input  wire              frame_sync_pin,
  output reg               short_frame_event,
  output reg               dsp_state_flush,
  input  wire              notch_enable,
  input  wire              sample_tick,
  output reg               notch_output_use,
  input  wire              soft_mute_active,
  input  wire [AUD_W-1:0]  dac_limiter_in,
  output reg  [AUD_W-1:0]  dac_limiter_out,
  input  wire              pll_locked,
  output reg               pll_clock_pass,
  input  wire              dac_ctl_osr_bit,
  output reg               dac_osr_256,
  input  wire [7:0]        auto_tieoff_switch,
  input  wire [7:0]        manual_switch_bits,
  output reg  [7:0]        tieoff_switch_closed
);

  reg  [8:0]  enh1_q;
  reg  [8:0]  enh2_q;
  reg  [8:0]  misc_q;
  reg  [8:0]  tie_q;
  reg  [2:0]  mode_sync_q;
  reg         mode_state_q;
  reg  [2:0]  fs_sync_q;
  reg         fs_state_q;
  reg  [8:0]  frame_cnt_q;
  reg         frame_seen_q;
  reg  [9:0]  notch_cnt_q;
  reg         notch_en_q;
  reg  [8:0]  rdata_d;
  reg  [8:0]  thr_d;
  wire        fs_rise;
  wire        mode_agree;
  wire        fs_agree;
  reg  [5:0]  left_ext;
  reg  [7:0]  right_ext;

  // register writes, gain fields and reserved bits not stored
  always @(posedge clock) begin
    if (rst) begin
      // (R15) bank resets
      enh1_q <= `CDMCB_RESET_VAL;
      enh2_q <= `CDMCB_RESET_VAL;
      misc_q <= `CDMCB_RESET_VAL;
      tie_q  <= `CDMCB_RESET_VAL;
    end else if (reg_wr) begin
      // (R17) gain writes dropped
      case (reg_addr)
        `CDMCB_ADDR_ENH1:   enh1_q <= {reg_wdata[8:6], 6'h00};
        `CDMCB_ADDR_ENH2:   enh2_q <= {reg_wdata[8], 8'h00};
        `CDMCB_ADDR_MISC:   misc_q <= reg_wdata;
        `CDMCB_ADDR_TIEOFF: tie_q  <= {reg_wdata[8], 8'h00};
        default: ;
      endcase
    end
  end

  // gain values widened to their field slots
  always @* begin
    left_ext              = 6'h00;
    right_ext             = 8'h00;
    left_ext[GAIN_W-1:0]  = left_gain;
    right_ext[GAIN_W-1:0] = right_gain;
  end

  // read mux
  always @* begin
    rdata_d = 9'h000;
    case (reg_addr)
      // (R4) live gain readback
      `CDMCB_ADDR_ENH1:   rdata_d = {enh1_q[8:6], left_ext};
      `CDMCB_ADDR_ENH2:   rdata_d = {enh2_q[8], right_ext};
      `CDMCB_ADDR_MISC:   rdata_d = misc_q;
      `CDMCB_ADDR_TIEOFF: rdata_d = tie_q;
      default:            rdata_d = 9'h000;
    endcase
  end

  always @(posedge clock) begin
    if (rst)
      reg_rdata <= 9'h000;
    else if (reg_rd)
      reg_rdata <= rdata_d;
  end

  // short frame threshold decode
  always @* begin
    // (R7) threshold codes
    case (misc_q[`CDMCB_THR_HI:`CDMCB_THR_LO])
      2'b01:   thr_d = `CDMCB_THR_253;
      2'b10:   thr_d = `CDMCB_THR_254;
      default: thr_d = `CDMCB_THR_255;
    endcase
  end

  // pin synchronisers
  always @(posedge clock) begin
    if (rst) begin
      mode_sync_q  <= 3'b000;
      mode_state_q <= 1'b0;
      fs_sync_q    <= 3'b000;
      fs_state_q   <= 1'b0;
    end else begin
      mode_sync_q <= {mode_sync_q[1:0], mode_pin};
      fs_sync_q   <= {fs_sync_q[1:0], frame_sync_pin};
      if (mode_agree)
        mode_state_q <= mode_sync_q[2];
      if (fs_agree)
        fs_state_q <= fs_sync_q[2];
    end
  end

  assign mode_agree = (mode_sync_q[1] == mode_sync_q[2]);
  assign fs_agree   = (fs_sync_q[1] == fs_sync_q[2]);
  assign fs_rise    = fs_agree & fs_sync_q[2] & ~fs_state_q;

  // frame length counter and short frame event
  always @(posedge clock) begin
    if (rst) begin
      frame_cnt_q       <= 9'h000;
      frame_seen_q      <= 1'b0;
      short_frame_event <= 1'b0;
      dsp_state_flush   <= 1'b0;
    end else begin
      short_frame_event <= 1'b0;
      dsp_state_flush   <= 1'b0;
      if (fs_rise) begin
        frame_cnt_q  <= 9'h001;
        frame_seen_q <= 1'b1;
        // (R9) detection off at 1
        if (frame_seen_q && !misc_q[`CDMCB_BIT_DET_OFF] && frame_cnt_q < thr_d) begin
          short_frame_event <= 1'b1;
          // (R8) flush when enabled
          dsp_state_flush   <= misc_q[`CDMCB_BIT_FLUSH];
        end
      end else if (frame_cnt_q != 9'h1ff) begin
        frame_cnt_q <= frame_cnt_q + 9'h001;
      end
    end
  end

  // notch settle counter
  always @(posedge clock) begin
    if (rst) begin
      notch_cnt_q      <= 10'h000;
      notch_en_q       <= 1'b0;
      notch_output_use <= 1'b0;
    end else begin
      notch_en_q <= notch_enable;
      if (!notch_enable || !notch_en_q)
        notch_cnt_q <= 10'h000;
      else if (sample_tick && notch_cnt_q != `CDMCB_NOTCH_SAMPLES)
        notch_cnt_q <= notch_cnt_q + 10'h001;
      // (R10) delayed or immediate use
      notch_output_use <= notch_enable & notch_en_q &
                          (misc_q[`CDMCB_BIT_NOTCH_DLY] | (notch_cnt_q == `CDMCB_NOTCH_SAMPLES));
    end
  end

  // datapath and control outputs
  always @(posedge clock) begin
    if (rst) begin
      level_detect_value   <= {PEAK_W{1'b0}};
      gate_detect_value    <= {PEAK_W{1'b0}};
      target_table_select  <= 1'b0;
      fast_limiter_active  <= 1'b1;
      four_wire_mode       <= 1'b0;
      dac_limiter_out      <= {AUD_W{1'b0}};
      pll_clock_pass       <= 1'b0;
      dac_osr_256          <= 1'b0;
      tieoff_switch_closed <= 8'h00;
    end else begin
      // (R1) target table
      target_table_select <= enh1_q[`CDMCB_BIT_TABLE];
      // (R2) level threshold source
      level_detect_value  <= enh1_q[`CDMCB_BIT_LVL_SRC] ? peak_p2p : peak_rect;
      // (R3) gate threshold source
      gate_detect_value   <= enh1_q[`CDMCB_BIT_GATE_SRC] ? peak_p2p : peak_rect;
      // (R5) limiter active low
      fast_limiter_active <= ~enh2_q[`CDMCB_BIT_LIM_DIS];
      // (R6) forced 4-wire mode
      four_wire_mode      <= misc_q[`CDMCB_BIT_FORCE4W] | mode_state_q;
      // (R11) exact zero mute
      dac_limiter_out     <= (soft_mute_active & misc_q[`CDMCB_BIT_ZERO_MUTE]) ? {AUD_W{1'b0}} : dac_limiter_in;
      // (R12) unlocked pll gate
      pll_clock_pass      <= pll_locked | misc_q[`CDMCB_BIT_PLL_PASS];
      // (R13) oversampling override
      dac_osr_256         <= misc_q[`CDMCB_BIT_OSR_OVR] | dac_ctl_osr_bit;
      // (R14) (R16) manual tie-off override
      tieoff_switch_closed <= tie_q[`CDMCB_BIT_MAN_EN] ? manual_switch_bits : auto_tieoff_switch;
    end
  end

endmodule
`default_nettype wire

/* sim/cdmcb_bank_chk.sv */
// Purpose: port assertions of the dsp misc control bank
// Assumes: one clock, synchronous active high reset
// Notes:   read data one cycle after the read strobe
`default_nettype none
module cdmcb_bank_chk #(
  parameter GAIN_W = 6
) (
  input wire logic              clock,
  input wire logic              rst,
  input wire logic [6:0]        reg_addr,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [8:0]        reg_rdata,
  input wire logic [GAIN_W-1:0] left_gain,
  input wire logic [GAIN_W-1:0] right_gain,
  input wire logic              target_table_select,
  input wire logic              fast_limiter_active,
  input wire logic              short_frame_event,
  input wire logic              dsp_state_flush,
  input wire logic              pll_locked,
  input wire logic              pll_clock_pass,
  input wire logic              dac_ctl_osr_bit,
  input wire logic              dac_osr_256
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_EVENT_PULSE: assert property (short_frame_event |=> !short_frame_event) else $error("event too long");
  AST_FLUSH_PULSE: assert property (dsp_state_flush |=> !dsp_state_flush) else $error("flush too long");
  AST_FLUSH_EVENT: assert property (dsp_state_flush |-> short_frame_event) else $error("flush without event");
  AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  AST_LEFT_GAIN: assert property (reg_rd && reg_addr == 7'h46 |=> reg_rdata[5:0] == $past(left_gain))
    else $error("left gain readback wrong");
  AST_RIGHT_GAIN: assert property (reg_rd && reg_addr == 7'h47 |=> reg_rdata[7:0] == {2'b00, $past(right_gain)})
    else $error("right gain readback wrong");
  AST_LIMITER: assert property (reg_rd && !reg_wr && reg_addr == 7'h47 |=> fast_limiter_active == !reg_rdata[8])
    else $error("limiter state wrong");
  AST_TABLE: assert property (reg_rd && !reg_wr && reg_addr == 7'h46 |=> target_table_select == reg_rdata[8])
    else $error("table select wrong");
  AST_PLL_PASS: assert property (pll_locked |=> pll_clock_pass) else $error("locked clock blocked");
  AST_OSR_FOLLOW: assert property (dac_ctl_osr_bit |=> dac_osr_256) else $error("oversampling wrong");
endmodule
bind cdmcb_bank cdmcb_bank_chk #(.GAIN_W(GAIN_W)) chk (.clock, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
  .left_gain, .right_gain, .target_table_select, .fast_limiter_active, .short_frame_event, .dsp_state_flush,
  .pll_locked, .pll_clock_pass, .dac_ctl_osr_bit, .dac_osr_256);
`default_nettype wire

/* sim/cdmcb_bank_test.sv */
// Purpose: self-checking bench of the dsp misc control bank
// Assumes: read data one cycle after the read strobe
// Notes:   frame events counted over whole frames
`default_nettype none
module cdmcb_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst, reg_wr, reg_rd, mode_pin, frame_sync_pin, notch_enable, sample_tick;
  logic        soft_mute_active, pll_locked, dac_ctl_osr_bit, target_table_select, fast_limiter_active;
  logic        four_wire_mode, short_frame_event, dsp_state_flush, notch_output_use, pll_clock_pass, dac_osr_256;
  logic [6:0]  reg_addr;
  logic [8:0]  reg_wdata, reg_rdata;
  logic [5:0]  left_gain, right_gain;
  logic [15:0] peak_rect, peak_p2p, level_detect_value, gate_detect_value;
  logic [23:0] dac_limiter_in, dac_limiter_out;
  logic [7:0]  auto_tieoff_switch, manual_switch_bits, tieoff_switch_closed;
  int          err_count, tests_run, ev_n, fl_n;
  cdmcb_bank dut (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .left_gain, .right_gain,
    .peak_rect, .peak_p2p, .level_detect_value, .gate_detect_value, .target_table_select, .fast_limiter_active,
    .mode_pin, .four_wire_mode, .frame_sync_pin, .short_frame_event, .dsp_state_flush, .notch_enable,
    .sample_tick, .notch_output_use, .soft_mute_active, .dac_limiter_in, .dac_limiter_out, .pll_locked,
    .pll_clock_pass, .dac_ctl_osr_bit, .dac_osr_256, .auto_tieoff_switch, .manual_switch_bits,
    .tieoff_switch_closed);
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    ev_n += short_frame_event;
    fl_n += dsp_state_flush;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    cyc(1);
    reg_wr = 0;
    cyc(1);
  endtask
  task automatic rd(input logic [6:0] a, input logic [8:0] e);
    reg_addr = a;
    reg_rd = 1;
    cyc(1);
    reg_rd = 0;
    cyc(1);
    chk(24'(reg_rdata), 24'(e));
  endtask
  task automatic frame(input int p);
    frame_sync_pin = 1;
    cyc(8);
    frame_sync_pin = 0;
    cyc(p - 8);
  endtask
  task automatic test_done;
    if (err_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge clock);
    err_count++;
    test_done;
  end
  initial begin
    rst = 1;
    {reg_wr, reg_rd, mode_pin, frame_sync_pin, notch_enable, sample_tick} = '0;
    {soft_mute_active, pll_locked, dac_ctl_osr_bit, reg_addr, reg_wdata, left_gain, right_gain} = '0;
    {peak_rect, peak_p2p, dac_limiter_in, auto_tieoff_switch, manual_switch_bits} = '0;
    cyc(3);
    rst = 0;
    cyc(1);
    chk(24'(fast_limiter_active), 24'h1);
    rd(7'h46, 9'h000);
    rd(7'h47, 9'h000);
    rd(7'h49, 9'h000);
    rd(7'h48, 9'h000);
    left_gain = 6'h2a;
    right_gain = 6'h15;
    peak_rect = 16'h1234;
    peak_p2p = 16'hbeef;
    wr(7'h46, 9'h1ff);
    wr(7'h47, 9'h1ff);
    rd(7'h46, 9'h1ea);
    rd(7'h47, 9'h115);
    chk(24'(target_table_select), 24'h1);
    chk(24'(fast_limiter_active), 24'h0);
    chk(24'(gate_detect_value), 24'hbeef);
    wr(7'h46, 9'h080);
    chk(24'(target_table_select), 24'h0);
    chk(24'(level_detect_value), 24'hbeef);
    chk(24'(gate_detect_value), 24'h1234);
    soft_mute_active = 1;
    dac_limiter_in = 24'habcdef;
    manual_switch_bits = 8'h5a;
    auto_tieoff_switch = 8'ha5;
    wr(7'h49, 9'h107);
    wr(7'h4a, 9'h100);
    rd(7'h4a, 9'h100);
    chk({four_wire_mode, pll_clock_pass, dac_osr_256, tieoff_switch_closed}, 24'h75a);
    chk(dac_limiter_out, 24'h0);
    wr(7'h49, 9'h000);
    wr(7'h4a, 9'h000);
    chk({four_wire_mode, pll_clock_pass, dac_osr_256, tieoff_switch_closed}, 24'h0a5);
    chk(dac_limiter_out, 24'habcdef);
    {mode_pin, pll_locked, dac_ctl_osr_bit, notch_enable} = 4'hf;
    repeat (512) begin
      sample_tick = 1;
      cyc(1);
      sample_tick = 0;
      cyc(1);
    end
    chk({four_wire_mode, pll_clock_pass, dac_osr_256, notch_output_use}, 24'he);
    sample_tick = 1;
    cyc(1);
    sample_tick = 0;
    cyc(2);
    chk(24'(notch_output_use), 24'h1);
    notch_enable = 0;
    wr(7'h49, 9'h008);
    notch_enable = 1;
    cyc(3);
    chk(24'(notch_output_use), 24'h1);
    wr(7'h49, 9'h060);
    frame(300);
    frame(253);
    frame(252);
    frame(300);
    chk(24'({ev_n[3:0], fl_n[3:0]}), 24'h11);
    wr(7'h49, 9'h070);
    frame(252);
    frame(252);
    frame(300);
    chk(24'(ev_n[3:0]), 24'h1);
    wr(7'h49, 9'h080);
    frame(300);
    frame(254);
    frame(253);
    frame(300);
    wr(7'h49, 9'h0c0);
    frame(255);
    frame(254);
    frame(300);
    chk(24'({ev_n[3:0], fl_n[3:0]}), 24'h31);
    test_done;
  end
endmodule
`default_nettype wire
